/* shared/ttc_map.svh */
// Constants of the trigger and timing configuration block
`ifndef TTC_MAP_SVH
`define TTC_MAP_SVH
`define TTC_NUM_INPUTS 5
`define TTC_NUM_CHANNELS 4
`define TTC_MODE_PER_START 1'h0
`define TTC_MODE_FREE_RUNNING 1'h1
`define TTC_SRC_BIT_START 0
`define TTC_SRC_BIT_SELF 14
`define TTC_SRC_BIT_CONST 15
`define TTC_SRC_MASK_DEFAULT 16'h0001
`define TTC_SRC_MASK_EMPTY 16'h0000
`define TTC_SELF_M_MIN_FREE 32'h0000001f
`define TTC_SELF_M_MAX_FREE 32'h04a817c8
`define TTC_VETO_MAX 31'h7fffffff
`define TTC_DELAY_MAX 10'h3ff
`define TTC_DELAY_STEP_PS 200
`define TTC_LFSR_SEED 32'h0000_0001
`define TTC_LFSR_TAPS 32'h8020_0003
`endif

/* shared/ttc_pkg.sv */
// Types of the trigger and timing configuration block
package ttc_pkg;
    typedef enum logic [0:0] {
        TTC_GEN_IDLE = 1'b0,
        TTC_GEN_RUN = 1'b1
    } ttc_gen_state_e;
    typedef enum logic [0:0] {
        TTC_MODE_PER_START = 1'b0,
        TTC_MODE_FREE_RUNNING = 1'b1
    } ttc_mode_e;
    typedef logic [15:0] ttc_count_t;
    typedef logic [30:0] ttc_bin_t;
endpackage

/* verilog/ttc_pulse_gen.sv */
// One timing pulse generator with window, polarity, restart and connector drive
`timescale 1ns/1ps
`default_nettype none
module ttc_pulse_gen
    import ttc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic trig,
    input wire logic gen_en,
    input wire logic negate,
    input wire logic restart,
    input wire logic drive_out,
    input wire ttc_count_t win_start,
    input wire ttc_count_t win_stop,
    output logic pulse_out,
    output logic conn_out,
    output logic conn_oe
);
    ttc_gen_state_e state_r;
    ttc_count_t timer_r;
    logic active_r;
    logic active_nxt;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            state_r <= TTC_GEN_IDLE;
            timer_r <= 16'h0000;
        end else if (!gen_en) begin
            state_r <= TTC_GEN_IDLE;
            timer_r <= 16'h0000;
        end else begin
            unique case (state_r)
                TTC_GEN_IDLE: begin
                    if (trig) begin
                        state_r <= TTC_GEN_RUN;
                        timer_r <= 16'h0000;
                    end
                end
                TTC_GEN_RUN: begin
                    if (trig && restart) begin
                        timer_r <= win_start;
                    end else if (timer_r >= win_stop) begin
                        state_r <= TTC_GEN_IDLE;
                    end else begin
                        timer_r <= timer_r + 16'h0001;
                    end
                end
            endcase
        end
    end

    // Window is start <= timer < stop, counted from the trigger
    always_comb begin
        active_nxt = gen_en && (state_r == TTC_GEN_RUN) && (timer_r >= win_start) && (timer_r < win_stop);
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            active_r <= 1'b0;
        end else begin
            active_r <= active_nxt;
        end
    end

    assign pulse_out = active_r ^ negate;
    assign conn_out = pulse_out;
    assign conn_oe = drive_out;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    gen_idle_level_a: assert property (!gen_en ##1 !gen_en |-> pulse_out == negate)
        else $error("Disabled generator output not at idle level");
    gen_restart_a: assert property (gen_en && state_r == TTC_GEN_RUN && trig && restart
        ##1 gen_en |-> timer_r == $past(win_start))
        else $error("Restart did not reload the start count");
    gen_start_a: assert property ($rose(state_r == TTC_GEN_RUN) && gen_en |-> timer_r == 16'h0000)
        else $error("Generator did not start counting from zero");
    gen_conn_a: assert property (conn_oe == drive_out && conn_out == pulse_out)
        else $error("Connector does not follow generator");
    gen_pulse_c: cover property ($rose(active_r));
endmodule
`default_nettype wire

/* verilog/ttc_top.sv */
// Trigger, self-trigger, timing generators and hit qualification of a common-start TDC
// Functional notes
// - Mode code 0 groups hits per start event; code 1 runs continuously.
// - Self-trigger gap is base interval plus random 1..2^N, minus one cycle.
// - Self-trigger always runs; generator source masks and the free-running mode decide its use.
// - A nonzero suppress setting drops empty groups from the output stream.
// - Per input, rising and falling selects choose which edges make events.
// - Edge events feed both pulse generators and the measurement side.
// - Five generators: index 0 tied to start, 1..4 to stops A..D.
// - Each generator has an activation bit and an output invert bit.
// - Generator output is asserted from start count to stop count after trigger.
// - With restart set, a trigger while running reloads the timer with start.
// - Connector drive puts the generator output onto its input connector.
// - Source mask: bit 0 start, 1..4 A..D, 14 self-trigger, 15 constant one.
// - Each stop channel records hits only while its enable bit is set.
// - Only hits between veto window start and end are recorded.
// - Each input holds a delay setting from 0 to 1023 steps.
`timescale 1ns/1ps
`default_nettype none
`include "ttc_map.svh"
module ttc_top
    import ttc_pkg::*;
(
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic mode_sel,
    input wire logic [31:0] suppress_hitless_groups,
    input wire logic [4:0] in_pin,
    input wire logic [4:0] edge_rise_en,
    input wire logic [4:0] edge_fall_en,
    input wire logic [31:0] self_period,
    input wire logic [4:0] self_jitter_exp,
    input wire logic [4:0] gen_en,
    input wire logic [4:0] gen_negate,
    input wire logic [4:0] gen_restart,
    input wire logic [4:0] gen_drive_out,
    input wire logic [79:0] gen_win_start,
    input wire logic [79:0] gen_win_stop,
    input wire logic [79:0] gen_src_mask,
    input wire logic [3:0] chan_en,
    input wire logic [123:0] veto_start,
    input wire logic [123:0] veto_end,
    input wire logic [49:0] delay_set,
    output logic [4:0] trig_evt,
    output logic self_fire,
    output logic [4:0] gen_pulse,
    output logic [4:0] conn_out,
    output logic [4:0] conn_oe,
    output logic [3:0] hit_valid,
    output logic [30:0] hit_stamp,
    output logic group_emit,
    output logic group_has_hits,
    output logic [49:0] delay_tap
);
    logic [4:0] pin_s1_r;
    logic [4:0] pin_s2_r;
    logic [4:0] pin_d_r;
    logic [4:0] trig_evt_r;
    logic [31:0] lfsr_r;
    logic [32:0] self_cnt_r;
    logic self_fire_r;
    logic [31:0] jit_mask;
    logic [32:0] gap_m1;
    logic [15:0] src_vec;
    logic [4:0] gen_trig;
    ttc_bin_t bin_r;
    logic ref_evt;
    logic started_r;
    logic grp_hit_r;
    logic [3:0] hit_valid_r;
    logic [3:0] hit_now;
    ttc_bin_t hit_stamp_r;
    logic group_emit_r;
    logic group_has_hits_r;
    logic [49:0] delay_tap_r;

    // Pins are asynchronous: two flops before any edge logic
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_r <= 5'h00;
            pin_s2_r <= 5'h00;
            pin_d_r <= 5'h00;
        end else begin
            pin_s1_r <= in_pin;
            pin_s2_r <= pin_s1_r;
            pin_d_r <= pin_s2_r;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            trig_evt_r <= 5'h00;
        end else begin
            trig_evt_r <= (edge_rise_en & pin_s2_r & ~pin_d_r) | (edge_fall_en & ~pin_s2_r & pin_d_r);
        end
    end
    assign trig_evt = trig_evt_r;

    // Free-running self-trigger with LFSR jitter; software has no enable for it
    always_comb begin
        jit_mask = ~(32'hffffffff << self_jitter_exp);
        gap_m1 = {1'b0, self_period} + {1'b0, lfsr_r & jit_mask};
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            lfsr_r <= `TTC_LFSR_SEED;
        end else begin
            lfsr_r <= (lfsr_r >> 1) ^ (lfsr_r[0] ? `TTC_LFSR_TAPS : 32'h0000_0000);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            self_cnt_r <= 33'h0_0000_0000;
            self_fire_r <= 1'b0;
        end else if (self_cnt_r == 33'h0_0000_0000) begin
            self_cnt_r <= gap_m1 - 33'h0_0000_0001;
            self_fire_r <= 1'b1;
        end else begin
            self_cnt_r <= self_cnt_r - 33'h0_0000_0001;
            self_fire_r <= 1'b0;
        end
    end
    assign self_fire = self_fire_r;

    always_comb begin
        src_vec = 16'h0000;
        src_vec[4:0] = trig_evt_r;
        src_vec[`TTC_SRC_BIT_SELF] = self_fire_r;
        src_vec[`TTC_SRC_BIT_CONST] = 1'b1;
    end

    for (genvar g = 0; g < `TTC_NUM_INPUTS; g++) begin : gen_tpg
        assign gen_trig[g] = |(src_vec & gen_src_mask[16*g +: 16]);
        ttc_pulse_gen u_gen (
            .clk_sys(clk_sys),
            .rst_b(rst_b),
            .trig(gen_trig[g]),
            .gen_en(gen_en[g]),
            .negate(gen_negate[g]),
            .restart(gen_restart[g]),
            .drive_out(gen_drive_out[g]),
            .win_start(gen_win_start[16*g +: 16]),
            .win_stop(gen_win_stop[16*g +: 16]),
            .pulse_out(gen_pulse[g]),
            .conn_out(conn_out[g]),
            .conn_oe(conn_oe[g])
        );
    end

    // Group reference: start events when grouped, self-trigger when continuous
    assign ref_evt = (mode_sel == `TTC_MODE_FREE_RUNNING) ? self_fire_r : trig_evt_r[0];

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bin_r <= 31'h0000_0000;
            started_r <= 1'b0;
        end else if (ref_evt) begin
            bin_r <= 31'h0000_0000;
            started_r <= 1'b1;
        end else if (bin_r != `TTC_VETO_MAX) begin
            bin_r <= bin_r + 31'h0000_0001;
        end
    end

    for (genvar c = 0; c < `TTC_NUM_CHANNELS; c++) begin : gen_hit
        assign hit_now[c] = started_r && !ref_evt && chan_en[c] && trig_evt_r[c+1]
            && bin_r >= veto_start[31*c +: 31] && bin_r <= veto_end[31*c +: 31];
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            hit_valid_r <= 4'h0;
            hit_stamp_r <= 31'h0000_0000;
        end else begin
            hit_valid_r <= hit_now;
            if (|hit_now) begin
                hit_stamp_r <= bin_r;
            end
        end
    end
    assign hit_valid = hit_valid_r;
    assign hit_stamp = hit_stamp_r;

    // Group close: an empty group is dropped when suppression is set
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            grp_hit_r <= 1'b0;
            group_emit_r <= 1'b0;
            group_has_hits_r <= 1'b0;
        end else begin
            group_emit_r <= 1'b0;
            if (ref_evt) begin
                group_emit_r <= started_r && ((suppress_hitless_groups == 32'h0000_0000) || grp_hit_r);
                group_has_hits_r <= grp_hit_r;
                grp_hit_r <= 1'b0;
            end else if (|hit_now) begin
                grp_hit_r <= 1'b1;
            end
        end
    end
    assign group_emit = group_emit_r;
    assign group_has_hits = group_has_hits_r;

    for (genvar d = 0; d < `TTC_NUM_INPUTS; d++) begin : gen_dly
        always_ff @(posedge clk_sys or negedge rst_b) begin
            if (!rst_b) begin
                delay_tap_r[10*d +: 10] <= 10'h000;
            end else begin
                delay_tap_r[10*d +: 10] <= delay_set[10*d +: 10];
            end
        end
    end
    assign delay_tap = delay_tap_r;

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);

    edge_select_a: assert property (pin_s2_r[0] && !pin_d_r[0] |=> trig_evt_r[0] == $past(edge_rise_en[0]))
        else $error("Rising edge select not honoured");
    fall_select_a: assert property (!pin_s2_r[1] && pin_d_r[1] |=> trig_evt_r[1] == $past(edge_fall_en[1]))
        else $error("Falling edge select not honoured");
    // Gap is fixed by the settings seen at the reload edge, one cycle before the pulse shows
    self_gap_a: assert property (self_fire_r && $past(self_period) == 32'h0000_0008
        && $past(self_jitter_exp) == 5'h00 |-> ##8 self_fire_r)
        else $error("Self-trigger gap wrong");
    self_quiet_a: assert property (self_fire_r |=> !self_fire_r || $past(gap_m1, 2) <= 33'h0_0000_0001)
        else $error("Self-trigger fired too soon");
    chan_gate_a: assert property (!$past(chan_en[2]) |-> !hit_valid_r[2])
        else $error("Hit recorded on disabled channel");
    veto_window_a: assert property (hit_valid_r[0] |-> hit_stamp_r >= $past(veto_start[30:0])
        && hit_stamp_r <= $past(veto_end[30:0]))
        else $error("Hit outside veto window");
    empty_drop_a: assert property (group_emit_r && suppress_hitless_groups != 32'h0000_0000
        && $stable(suppress_hitless_groups) |-> group_has_hits_r)
        else $error("Empty group emitted under suppression");
    mode_ref_a: assert property (mode_sel == `TTC_MODE_PER_START && trig_evt_r[0] |=> bin_r == 31'h0000_0000)
        else $error("Start event did not open a group");
    const_src_a: assert property (gen_src_mask[`TTC_SRC_BIT_CONST] |-> gen_trig[0])
        else $error("Constant-one source did not trigger");

    grp_emit_c: cover property (group_emit_r && group_has_hits_r);
    free_run_c: cover property (mode_sel == `TTC_MODE_FREE_RUNNING && self_fire_r);
    hit_c: cover property (|hit_valid_r);
endmodule
`default_nettype wire

/* tb/ttc_pulse_src.sv */
// Far-side pulse sources on the start and stop connectors
`timescale 1ns/1ps
`default_nettype none
module ttc_pulse_src (
    input wire logic clk_sys,
    input wire logic [4:0] conn_oe,
    input wire logic [4:0] conn_out,
    output logic [4:0] pin
);
    logic [4:0] lvl = 5'h00;
    // A connector the device drives shows the device level, otherwise the source level
    assign pin = (conn_oe & conn_out) | (~conn_oe & lvl);
    // Pulses last whole cycles, so the input synchroniser never misses them
    task automatic pulse(input int i, input int w);
        @(negedge clk_sys);
        lvl[i] = 1'b1;
        repeat (w) @(negedge clk_sys);
        lvl[i] = 1'b0;
    endtask
endmodule
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench of the trigger and timing configuration block
`timescale 1ns/1ps
`default_nettype none
module testbench;
    localparam logic [49:0] dly_pat = {10'h3ff, 10'h000, 10'h155, 10'h001, 10'h200};
    logic clk_sys = 1'b0;
    logic rst_b = 1'b0;
    logic mode_sel = 1'b0;
    logic [31:0] suppress_hitless_groups = 32'h0;
    logic [31:0] self_period = 32'h8;
    logic [4:0] self_jitter_exp = 5'h0;
    logic [4:0] edge_rise_en = 5'h1f;
    logic [4:0] edge_fall_en = 5'h0;
    logic [4:0] gen_en = 5'h0;
    logic [4:0] gen_negate = 5'h15;
    logic [4:0] gen_restart = 5'h0;
    logic [4:0] gen_drive_out = 5'h0a;
    logic [79:0] gen_win_start = 80'h0;
    logic [79:0] gen_win_stop = 80'h0;
    logic [79:0] gen_src_mask = 80'h0;
    logic [3:0] chan_en = 4'h0;
    logic [123:0] veto_start = 124'h0;
    logic [123:0] veto_end = 124'h0;
    logic [49:0] delay_set = 50'h0;
    wire [4:0] in_pin;
    logic [4:0] trig_evt, gen_pulse, conn_out, conn_oe, hit_valid;
    logic self_fire, group_emit, group_has_hits;
    logic [30:0] hit_stamp;
    logic [49:0] delay_tap;
    int cyc, last, gap, n_emit, n_hit, n_checks, err_total;
    int gmin = 999;
    int gmax = 0;
    int n_trig [5];

    ttc_top i_dut (
        .clk_sys, .rst_b, .mode_sel, .suppress_hitless_groups, .in_pin, .edge_rise_en, .edge_fall_en,
        .self_period, .self_jitter_exp, .gen_en, .gen_negate, .gen_restart, .gen_drive_out,
        .gen_win_start, .gen_win_stop, .gen_src_mask, .chan_en, .veto_start, .veto_end, .delay_set,
        .trig_evt, .self_fire, .gen_pulse, .conn_out, .conn_oe, .hit_valid, .hit_stamp,
        .group_emit, .group_has_hits, .delay_tap
    );
    ttc_pulse_src i_src (.clk_sys(clk_sys), .conn_oe(conn_oe), .conn_out(conn_out), .pin(in_pin));

    initial begin
        forever #12.5 clk_sys = ~clk_sys;
    end

    // Event counters and self-trigger gap tracking
    always @(negedge clk_sys) begin
        n_emit += int'(group_emit === 1'b1);
        n_hit += int'(hit_valid[0] === 1'b1);
        for (int i = 0; i < 5; i++) begin
            n_trig[i] += int'(trig_evt[i] === 1'b1);
        end
        if (self_fire === 1'b1) begin
            gap = cyc - last;
            last = cyc;
            gmin = (gap < gmin) ? gap : gmin;
            gmax = (gap > gmax) ? gap : gmax;
        end
    end

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 5000) begin
            err_total++;
            results();
        end
    end

    task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
        n_checks++;
        if (g !== e) begin
            err_total++;
            $display("BAD %s exp %0h got %0h", nm, e, g);
        end
    endtask

    task automatic results();
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    // Flags are enable, negate, restart, connector drive
    task automatic setg(input int g, input logic [15:0] a, input logic [15:0] b, input logic [15:0] m,
                        input logic [3:0] f);
        gen_win_start[16*g +: 16] = a;
        gen_win_stop[16*g +: 16] = b;
        gen_src_mask[16*g +: 16] = m;
        {gen_en[g], gen_negate[g], gen_restart[g], gen_drive_out[g]} = f;
    endtask

    // Pulse input s (twice if p2 > 0), measure delay and active length of generator g
    task automatic run(input int s, input int g, input int p2, output int d, output int len);
        int t;
        int a;
        t = -1;
        a = -1;
        len = 0;
        fork
            i_src.pulse(s, 2);
            if (p2 > 0) begin
                repeat (p2) @(negedge clk_sys);
                i_src.pulse(s, 2);
            end
        join_none
        for (int k = 0; k < 40; k++) begin
            @(negedge clk_sys);
            if (t < 0 && trig_evt[s] === 1'b1) t = k;
            if ((gen_pulse[g] ^ gen_negate[g]) === 1'b1) begin
                if (a < 0) a = k;
                len++;
            end
        end
        d = a - t;
    endtask

    // Start event, then a stop on channel 0 k cycles later
    task automatic hit(input int k);
        fork
            i_src.pulse(0, 2);
            begin
                repeat (k) @(negedge clk_sys);
                i_src.pulse(1, 2);
            end
        join
        repeat (12) @(negedge clk_sys);
    endtask

    initial begin
        int d;
        int len;
        repeat (10) @(negedge clk_sys);
        chk("reset pulse", 64'h15, gen_pulse);
        chk("reset oe", 64'h0a, conn_oe);
        rst_b = 1'b1;
        @(negedge clk_sys);
        gen_negate = 5'h00;
        gen_drive_out = 5'h00;
        for (int e = 0; e < 4; e++) begin
            for (int i = 0; i < 5; i++) begin
                edge_rise_en = {5{e[0]}};
                edge_fall_en = {5{e[1]}};
                n_trig[i] = 0;
                i_src.pulse(i, 3);
                repeat (6) @(negedge clk_sys);
                chk("edge count", (e & 1) + (e >> 1), n_trig[i]);
            end
        end
        edge_rise_en = 5'h1f;
        edge_fall_en = 5'h00;
        repeat (30) @(negedge clk_sys);
        chk("self gap", 8, gap);
        self_jitter_exp = 5'h2;
        repeat (20) @(negedge clk_sys);
        gmin = 999;
        gmax = 0;
        repeat (300) @(negedge clk_sys);
        chk("gap span", 1, gmin >= 8 && gmax <= 11 && gmin != gmax);
        self_jitter_exp = 5'h0;
        for (int g = 0; g < 5; g++) begin
            setg(g, 16'h2, 16'h5, 16'h1 << g, 4'b1000);
            run(g, g, 0, d, len);
            chk("win delay", 4, d);
            chk("win length", 3, len);
            setg(g, 16'h0, 16'h0, 16'h0, 4'b0000);
        end
        setg(0, 16'h0, 16'h1, 16'h1, 4'b1100);
        run(0, 0, 0, d, len);
        chk("neg delay", 2, d);
        chk("neg length", 1, len);
        chk("neg idle", 1, gen_pulse[0]);
        for (int r = 0; r < 2; r++) begin
            setg(0, 16'h1, 16'ha, 16'h1, {2'b10, r[0], 1'b0});
            run(0, 0, 4, d, len);
            chk("restart length", r ? 12 : 9, len);
        end
        setg(0, 16'h1, 16'h3, 16'h1, 4'b0100);
        run(0, 0, 0, d, len);
        chk("off length", 0, len);
        chk("off idle", 1, gen_pulse[0]);
        setg(0, 16'h1, 16'h3, 16'h0, 4'b1000);
        run(0, 0, 0, d, len);
        chk("empty length", 0, len);
        // Align to a self-trigger pulse so the 40-cycle window sees a fixed phase
        do @(negedge clk_sys); while (self_fire !== 1'b1);
        setg(0, 16'h0, 16'h2, 16'h4000, 4'b1000);
        run(1, 0, 0, d, len);
        chk("self source", 10, len);
        setg(0, 16'h0, 16'h2, 16'h8000, 4'b1000);
        run(1, 0, 0, d, len);
        chk("constant source", 1, len >= 16);
        setg(0, 16'h0, 16'h0, 16'h0, 4'b0000);
        setg(1, 16'h0, 16'h3, 16'h1, 4'b1001);
        n_trig[1] = 0;
        run(0, 1, 0, d, len);
        chk("connector oe", 1, conn_oe[1]);
        chk("connector loop", 1, n_trig[1]);
        setg(1, 16'h0, 16'h0, 16'h0, 4'b0000);
        veto_start[30:0] = 31'h4;
        veto_end[30:0] = 31'h8;
        for (int c = 0; c < 3; c++) begin
            chan_en = {3'h0, c != 2};
            n_hit = 0;
            hit(c == 1 ? 20 : 6);
            chk("hit count", c == 0, n_hit);
            if (c == 0) chk("stamp", 1, hit_stamp >= 4 && hit_stamp <= 8);
            chk("group hits", c == 1, group_has_hits);
        end
        for (int s = 0; s < 2; s++) begin
            suppress_hitless_groups = s ? 32'h0 : 32'h100;
            n_emit = 0;
            repeat (3) begin
                i_src.pulse(0, 2);
                repeat (10) @(negedge clk_sys);
            end
            chk("emits", s ? 3 : 0, n_emit);
        end
        self_period = 32'h28;
        veto_end[30:0] = 31'h7fffffff;
        for (int m = 0; m < 2; m++) begin
            mode_sel = m[0];
            n_emit = 0;
            repeat (200) @(negedge clk_sys);
            chk("mode emits", m, n_emit >= 4);
        end
        delay_set = dly_pat;
        repeat (3) @(negedge clk_sys);
        chk("delay tap", dly_pat, delay_tap);
        results();
    end
endmodule
`default_nettype wire
